// file: tb.sv
// Self-checking bench for the eight-bit timer with its shared divider.
// Assumes the pin model drives the count pin; all inputs, flag_clr included, change on falling edges.
`timescale 1ns/1ps
`default_nettype none

module tb;
    import tsp_pkg::*;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       opt_wr = 1'b0;
    logic [7:0] opt_wdata = 8'h00;
    logic       cnt_wr = 1'b0;
    logic [7:0] cnt_wdata = 8'h00;
    logic       flag_clr = 1'b0;
    logic       irq_en = 1'b0;
    logic       sleep = 1'b0;
    logic       sup_clr = 1'b0;
    logic       sup_tick = 1'b0;
    logic [7:0] opt_q;
    logic [7:0] cnt_q;
    logic       flag;
    logic       irq;
    logic       sup_out;
    logic       itick;
    logic       pin;
    logic [7:0] sup_seen = 8'h00;
    int         n_fail = 0;
    int         total_checks = 0;
    int         cycles = 0;
    logic [7:0] base;

    always #2 clk = ~clk;

    tsp_pin_model i_tsp_pin_model (.clk_sys_i(clk), .pin_o(pin));

    tsp_timer i_tsp_timer (
        .clk_sys_i(clk), .rst_i(rst), .option_wr_i(opt_wr), .option_wdata_i(opt_wdata),
        .option_o(opt_q), .count_wr_i(cnt_wr), .count_wdata_i(cnt_wdata),
        .count_register_o(cnt_q), .overflow_flag_clr_i(flag_clr),
        .overflow_irq_enable_i(irq_en), .overflow_flag_o(flag), .irq_o(irq),
        .sleep_i(sleep), .external_count_input_i(pin), .supervision_clear_i(sup_clr),
        .supervision_tick_i(sup_tick), .supervision_tick_o(sup_out), .instr_tick_o(itick)
    );

    always @(posedge clk) begin
        if (sup_out === 1'b1) sup_seen <= sup_seen + 8'h01;
    end

    task automatic give_verdict();
        if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // The ceiling sits well above the longest path through the tests.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic write_opt(input logic [7:0] v);
        @(negedge clk);
        opt_wr = 1'b1;
        opt_wdata = v;
        @(negedge clk);
        opt_wr = 1'b0;
    endtask

    task automatic write_cnt(input logic [7:0] v);
        @(negedge clk);
        cnt_wr = 1'b1;
        cnt_wdata = v;
        @(negedge clk);
        cnt_wr = 1'b0;
    endtask

    // Counts instruction ticks seen at falling edges; step lets the last one land.
    task automatic wait_ticks(input int n);
        repeat (n) begin
            @(negedge clk);
            while (itick !== 1'b1) @(negedge clk);
        end
    endtask

    task automatic step(input int n);
        wait_ticks(n);
        @(negedge clk);
    endtask

    task automatic pulse_sup(input int n, input bit clr);
        repeat (n) begin
            @(negedge clk);
            if (clr) sup_clr = 1'b1;
            else sup_tick = 1'b1;
            @(negedge clk);
            sup_clr = 1'b0;
            sup_tick = 1'b0;
        end
    endtask

    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check("option reset", opt_q, OPTION_RESET);
        check("count reset", cnt_q, 8'h00);
        check("flag reset", {7'h00, flag}, 8'h00);
        // Timer mode without prescaler: inhibit, increment and rollover.
        write_opt(8'h08);
        check("option readback", opt_q, 8'h08);
        wait_ticks(1);
        write_cnt(8'hFE);
        step(2);
        check("inhibited count", cnt_q, 8'hFE);
        step(1);
        check("timer step", cnt_q, 8'hFF);
        check("flag before wrap", {7'h00, flag}, 8'h00);
        step(1);
        check("wrapped count", cnt_q, 8'h00);
        check("flag after wrap", {7'h00, flag}, 8'h01);
        check("masked irq", {7'h00, irq}, 8'h00);
        irq_en = 1'b1;
        #1;
        check("enabled irq", {7'h00, irq}, 8'h01);
        step(3);
        check("flag is sticky", {7'h00, flag}, 8'h01);
        flag_clr = 1'b1;
        @(negedge clk);
        flag_clr = 1'b0;
        irq_en = 1'b0;
        check("flag cleared", {7'h00, flag}, 8'h00);
        // Sleep freezes the count.
        sleep = 1'b1;
        base = cnt_q;
        step(8);
        check("sleep count", cnt_q, base);
        sleep = 1'b0;
        // Every timer ratio: two increments per two full prescaled periods.
        pulse_sup(1, 1'b1);
        for (int r = 0; r < 8; r++) begin
            write_opt(8'h00 | 8'(r));
            write_cnt(8'h00);
            for (int i = 0; i < 2100 && cnt_q === 8'h00; i++) @(negedge clk);
            base = cnt_q;
            step(2 * (2 << r));
            check("prescaled count", cnt_q, base + 8'h02);
        end
        // Counter mode without prescaler, rising then falling edges.
        pulse_sup(1, 1'b1);
        write_cnt(8'h00);
        write_opt(8'h28);
        write_cnt(8'h40);
        repeat (12) @(negedge clk);
        i_tsp_pin_model.pulses(5, 4);
        repeat (8) @(negedge clk);
        check("rising edges", cnt_q, 8'h45);
        i_tsp_pin_model.set_level(1'b1);
        write_opt(8'h38);
        write_cnt(8'h50);
        repeat (12) @(negedge clk);
        i_tsp_pin_model.set_level(1'b0);
        repeat (8) @(negedge clk);
        check("falling edge", cnt_q, 8'h51);
        i_tsp_pin_model.set_level(1'b1);
        repeat (8) @(negedge clk);
        check("rising ignored", cnt_q, 8'h51);
        // Counter mode through the 1:4 prescaler; a count write clears it.
        i_tsp_pin_model.set_level(1'b0);
        pulse_sup(1, 1'b1);
        write_opt(8'h21);
        write_cnt(8'h60);
        repeat (12) @(negedge clk);
        i_tsp_pin_model.pulses(3, 4);
        repeat (8) @(negedge clk);
        check("divided pin", cnt_q, 8'h61);
        write_cnt(8'h70);
        repeat (12) @(negedge clk);
        i_tsp_pin_model.pulses(2, 4);
        repeat (8) @(negedge clk);
        check("divider cleared", cnt_q, 8'h71);
        // Divider on the supervision side, 1:4, cleared by the clear strobe.
        pulse_sup(1, 1'b1);
        write_cnt(8'h00);
        write_opt(8'h0A);
        base = sup_seen;
        repeat (3) begin
            pulse_sup(1, 1'b1);
            pulse_sup(2, 1'b0);
        end
        check("cleared postscaler", sup_seen, base);
        pulse_sup(4, 1'b0);
        check("postscaled ticks", sup_seen, base + 8'h01);
        pulse_sup(1, 1'b1);
        write_opt(8'h02);
        base = sup_seen;
        pulse_sup(3, 1'b0);
        check("undivided ticks", sup_seen, base + 8'h03);
        give_verdict();
    end
endmodule

`default_nettype wire

// file: tsp_divider.sv
// Shared eight-bit divider: prescaler of the timer or postscaler of the
// supervision timer. Assumes all strobes are one-cycle pulses on clk_sys_i.
`timescale 1ns/1ps
`default_nettype none

module tsp_divider (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    input  wire logic       clear_i,
    input  wire logic       to_timer_i,
    input  wire logic [2:0] ratio_i,
    input  wire logic       event_i,
    input  wire logic       sup_tick_i,
    output logic            timer_carry_o,
    output logic            timer_level_o,
    output logic            sup_tick_o
);
    import tsp_pkg::*;

    // ========================================================================
    // Divider state
    // ========================================================================
    function automatic logic [7:0] low_mask(input logic [3:0] n);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < 8; i++) begin
            m[i] = (i < int'(n));
        end
        return m;
    endfunction

    logic [7:0] count_q;
    logic [7:0] count_d;
    logic       step;

    always_comb begin
        step    = to_timer_i ? event_i : sup_tick_i; // RULE9
        count_d = count_q;
        if (clear_i) begin
            count_d = DIV_ZERO;
        end else if (step) begin
            count_d = count_q + COUNT_ONE;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            count_q <= DIV_ZERO;
        end else begin
            count_q <= count_d;
        end
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    // One carry per 2 to 256 timer events.
    assign timer_carry_o = to_timer_i & event_i & ~clear_i
                         & (&(count_q | ~low_mask({1'b0, ratio_i} + 4'h1))); // RULE8 RULE21
    // The selected bit toggles every half period, so it is symmetrical.
    assign timer_level_o = count_q[ratio_i]; // RULE17
    // Unassigned, the supervision ticks pass through undivided.
    assign sup_tick_o = to_timer_i ? sup_tick_i
                      : sup_tick_i & (&(count_q | ~low_mask({1'b0, ratio_i}))); // RULE9 RULE21

    // ========================================================================
    // Checks
    // ========================================================================
    a_clear_zeroes: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE10
        clear_i |=> count_q == DIV_ZERO)
        else $error("divider not cleared");
    a_sup_passthru: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE9
        (to_timer_i || ratio_i == 3'h0) |-> sup_tick_o == sup_tick_i)
        else $error("supervision tick not undivided");
    a_ratio_two: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE8
        to_timer_i && event_i && !clear_i && ratio_i == 3'h0 |-> timer_carry_o == count_q[0])
        else $error("ratio 1:2 carry wrong");

endmodule

`default_nettype wire

// file: tsp_pin_model.sv
// Model of the external count source that drives the timer's count pin.
// Assumes the bench calls its tasks; the pin holds its last level between bursts.
`timescale 1ns/1ps
`default_nettype none

module tsp_pin_model (
    input  wire logic clk_sys_i,
    output var logic  pin_o
);
    initial pin_o = 1'b0;

    task automatic set_level(input logic v);
        @(negedge clk_sys_i);
        pin_o = v;
    endtask

    // A half period of at least two clocks keeps each level visible to one sample.
    task automatic pulses(input int n, input int half);
        @(negedge clk_sys_i);
        repeat (n) begin
            pin_o = 1'b1;
            repeat (half) @(negedge clk_sys_i);
            pin_o = 1'b0;
            repeat (half) @(negedge clk_sys_i);
        end
    endtask
endmodule

`default_nettype wire

// file: tsp_pkg.sv
// Constants and types shared by the eight-bit timer and its shared divider.
// Assumes one system clock, four clock cycles to an instruction cycle.
package tsp_pkg;

    // ========================================================================
    // Option control field positions and reset value
    // ========================================================================
    localparam int unsigned OPT_CSS_BIT   = 5;
    localparam int unsigned OPT_EDGE_BIT  = 4;
    localparam int unsigned OPT_PSA_BIT   = 3;
    localparam int unsigned OPT_RATIO_LSB = 0;
    localparam int unsigned OPT_RATIO_MSB = 2;
    localparam logic [7:0]  OPTION_RESET  = 8'hFF;

    // ========================================================================
    // Count, divider and write inhibit values
    // ========================================================================
    localparam logic [7:0]  COUNT_MAX      = 8'hFF;
    localparam logic [7:0]  COUNT_ZERO     = 8'h00;
    localparam logic [7:0]  COUNT_ONE      = 8'h01;
    localparam logic [7:0]  DIV_ZERO       = 8'h00;
    localparam logic [1:0]  INHIBIT_CYCLES = 2'h2;
    localparam logic [1:0]  INHIBIT_NONE   = 2'h0;

    // ========================================================================
    // Internal clock phases, Gray coded around the instruction cycle
    // ========================================================================
    typedef enum logic [1:0] {
        TSP_Q1 = 2'b00,
        TSP_Q2 = 2'b01,
        TSP_Q3 = 2'b11,
        TSP_Q4 = 2'b10
    } tsp_phase_t;

endpackage

// file: tsp_timer.sv
// Eight-bit timer/counter with a shared eight-bit prescaler.
// Assumes clk_sys_i is the oscillator clock and all inputs are synchronous.
//
// Notes on behaviour
// RULE1 - Eight-bit count; rollover to zero sets flag.
// RULE2 - Source select clear: count every instruction cycle.
// RULE3 - Any count write stops counting two cycles.
// RULE4 - Source select set: count external pin edges.
// RULE5 - Edge select clear rising, set falling.
// RULE6 - Assign bit clear: prescaler to timer.
// RULE7 - Prescaler count is never readable or writable.
// RULE8 - Timer ratio 1:2 to 1:256 by field.
// RULE9 - One divider; unassigned side runs undivided.
// RULE10 - Count write clears prescaler when timer-assigned.
// RULE11 - Supervision clear clears prescaler when assigned.
// RULE12 - Interrupt request only while enable bit set.
// RULE13 - Software clears the flag; hardware never does.
// RULE14 - Timer stopped during sleep; no wake.
// RULE15 - Prescaler output sampled on phases two, four.
// RULE16 - Undivided pin high and low two periods.
// RULE17 - Pin divided before sampling, symmetrical output.
// RULE18 - Divided pin period four periods over ratio.
// RULE19 - Prescaler reassignment allowed at any time.
// RULE20 - Software uses safe sequence moving assignment back.
// RULE21 - Field doubles ratios; supervision 1:1 to 1:128.
// RULE22 - Option bits reset to all ones.
`timescale 1ns/1ps
`default_nettype none

module tsp_timer (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    input  wire logic       option_wr_i,
    input  wire logic [7:0] option_wdata_i,
    output logic      [7:0] option_o,
    input  wire logic       count_wr_i,
    input  wire logic [7:0] count_wdata_i,
    output logic      [7:0] count_register_o,
    input  wire logic       overflow_flag_clr_i,
    input  wire logic       overflow_irq_enable_i,
    output logic            overflow_flag_o,
    output logic            irq_o,
    input  wire logic       sleep_i,
    input  wire logic       external_count_input_i,
    input  wire logic       supervision_clear_i,
    input  wire logic       supervision_tick_i,
    output logic            supervision_tick_o,
    output logic            instr_tick_o
);
    import tsp_pkg::*;

    // ========================================================================
    // Internal clock phases
    // ========================================================================
    tsp_phase_t phase_q;
    tsp_phase_t phase_d;
    logic       instr_tick;
    logic       sample_now;

    always_comb begin
        unique case (phase_q)
            TSP_Q1: begin
                phase_d = TSP_Q2;
            end
            TSP_Q2: begin
                phase_d = TSP_Q3;
            end
            TSP_Q3: begin
                phase_d = TSP_Q4;
            end
            TSP_Q4: begin
                phase_d = TSP_Q1;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            phase_q <= TSP_Q1;
        end else begin
            phase_q <= phase_d;
        end
    end

    assign instr_tick   = (phase_q == TSP_Q4);
    assign sample_now   = (phase_q == TSP_Q2) || (phase_q == TSP_Q4); // RULE15
    assign instr_tick_o = instr_tick;

    // ========================================================================
    // Option control
    // ========================================================================
    logic [7:0] option_q;
    logic [7:0] option_d;
    logic       css;
    logic       edge_sel;
    logic       prescaler_assign;
    logic [2:0] ratio;

    // A new assignment takes effect at once; software orders the steps.
    always_comb begin
        option_d = option_q;
        if (option_wr_i) begin
            option_d = option_wdata_i; // RULE19
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            option_q <= OPTION_RESET; // RULE22
        end else begin
            option_q <= option_d;
        end
    end

    assign css      = option_q[OPT_CSS_BIT];
    assign edge_sel = option_q[OPT_EDGE_BIT];
    assign prescaler_assign      = option_q[OPT_PSA_BIT];
    assign ratio    = option_q[OPT_RATIO_MSB:OPT_RATIO_LSB];
    assign option_o = option_q;

    // ========================================================================
    // External source edge and sampling
    // ========================================================================
    logic src_level;
    logic src_prev_q;
    logic src_prev_d;
    logic src_rise;
    logic pre_out;
    logic samp_q;
    logic samp_d;
    logic rise_q;
    logic rise_d;
    logic timer_carry;
    logic timer_level;
    logic div_event;
    logic div_clear;

    // Inverting the pin turns a falling edge into a rising one.
    assign src_level = external_count_input_i ^ edge_sel; // RULE5
    assign src_rise  = src_level & ~src_prev_q;

    // The divider keeps counting pin edges in sleep; only the count stops.
    assign div_event = css ? src_rise : (instr_tick & ~sleep_i); // RULE4 RULE2
    assign div_clear = (count_wr_i & ~prescaler_assign) // RULE10
                     | (supervision_clear_i & prescaler_assign); // RULE11

    // Without the prescaler the pin level goes straight to the sampler.
    assign pre_out = prescaler_assign ? src_level : timer_level; // RULE17 RULE6

    always_comb begin
        src_prev_d = src_level;
        samp_d     = samp_q;
        rise_d     = 1'b0;
        if (sample_now) begin
            samp_d = pre_out; // RULE15
            rise_d = pre_out & ~samp_q;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            // Both start high, so no level seen at the first sample after
            // reset can pass for a rising edge, whatever the pin idles at.
            src_prev_q <= 1'b1;
            samp_q     <= 1'b1;
            rise_q     <= 1'b0;
        end else begin
            src_prev_q <= src_prev_d;
            samp_q     <= samp_d;
            rise_q     <= rise_d;
        end
    end

    // The divider count stays inside; nothing reads or loads it.
    tsp_divider u_div ( // RULE7
        .clk_sys_i     (clk_sys_i),
        .rst_i         (rst_i),
        .clear_i       (div_clear),
        .to_timer_i    (~prescaler_assign),
        .ratio_i       (ratio),
        .event_i       (div_event),
        .sup_tick_i    (supervision_tick_i),
        .timer_carry_o (timer_carry),
        .timer_level_o (timer_level),
        .sup_tick_o    (supervision_tick_o)
    );

    // ========================================================================
    // Count, write inhibit and overflow flag
    // ========================================================================
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic [1:0] inhibit_q;
    logic [1:0] inhibit_d;
    logic       flag_q;
    logic       flag_d;
    logic       raw_inc;
    logic       inc;
    logic       overflow;

    always_comb begin
        if (css) begin
            raw_inc = rise_q; // RULE4
        end else if (prescaler_assign) begin
            raw_inc = instr_tick; // RULE2
        end else begin
            raw_inc = timer_carry; // RULE8
        end
    end

    assign inc      = raw_inc & ~sleep_i & (inhibit_q == INHIBIT_NONE) & ~count_wr_i; // RULE14 RULE3
    assign overflow = inc & (count_q == COUNT_MAX); // RULE1

    always_comb begin
        count_d   = count_q;
        inhibit_d = inhibit_q;
        flag_d    = flag_q;
        if (count_wr_i) begin
            count_d   = count_wdata_i;
            inhibit_d = INHIBIT_CYCLES; // RULE3
        end else begin
            if (inc) begin
                count_d = count_q + COUNT_ONE; // RULE1
            end
            if (instr_tick && inhibit_q != INHIBIT_NONE) begin
                inhibit_d = inhibit_q - 2'h1;
            end
        end
        // A rollover in the clearing cycle keeps the flag set.
        if (overflow) begin
            flag_d = 1'b1; // RULE1
        end else if (overflow_flag_clr_i) begin
            flag_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            count_q   <= COUNT_ZERO;
            inhibit_q <= INHIBIT_NONE;
            flag_q    <= 1'b0;
        end else begin
            count_q   <= count_d;
            inhibit_q <= inhibit_d;
            flag_q    <= flag_d;
        end
    end

    assign count_register_o = count_q;
    assign overflow_flag_o  = flag_q;
    // Sleep stops the count, so no overflow can arrive to wake the core.
    assign irq_o = flag_q & overflow_irq_enable_i; // RULE12

    // ========================================================================
    // Checks
    // ========================================================================
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    a_write_inhibit: assert property ( // RULE3
        count_wr_i ##1 (!count_wr_i)[*5] |-> count_q == $past(count_wdata_i, 5))
        else $error("count moved during write inhibit");
    a_rollover_flag: assert property ( // RULE1
        overflow |=> flag_q && count_q == COUNT_ZERO)
        else $error("rollover did not set flag");
    a_flag_sticky: assert property ( // RULE13
        flag_q && !overflow_flag_clr_i |=> flag_q)
        else $error("flag cleared without software");
    a_irq_masked: assert property ( // RULE12
        !overflow_irq_enable_i |-> !irq_o)
        else $error("request while masked");
    a_sleep_stops: assert property ( // RULE14
        sleep_i && !count_wr_i |=> $stable(count_q) && !$rose(flag_q))
        else $error("count moved in sleep");
    a_timer_rate: assert property ( // RULE2
        !css && prescaler_assign && !sleep_i && !count_wr_i && instr_tick && inhibit_q == INHIBIT_NONE
        |=> count_q == $past(count_q) + COUNT_ONE)
        else $error("timer mode did not count");
    a_sample_phase: assert property ( // RULE15
        rise_q |-> $past(phase_q) == TSP_Q2 || $past(phase_q) == TSP_Q4)
        else $error("edge taken off sampling phase");
    a_option_reset: assert property ( // RULE22
        $past(rst_i) |-> option_q == OPTION_RESET)
        else $error("option not all ones after reset");
    a_counter_src: assert property ( // RULE4
        $past(css) && !$past(rise_q) && !$past(count_wr_i) |-> count_q == $past(count_q))
        else $error("counter mode counted without edge");
    a_wr_loads: assert property ( // RULE3
        count_wr_i |=> count_q == $past(count_wdata_i))
        else $error("count write not loaded");
    a_wrap_zero: assert property ( // RULE1
        $rose(flag_q) |-> count_q == COUNT_ZERO)
        else $error("flag set away from wrap");
    a_irq_follows: assert property ( // RULE12
        flag_q && overflow_irq_enable_i |-> irq_o)
        else $error("enabled flag gave no request");

    c_overflow:  cover property (overflow && overflow_irq_enable_i);
    c_wr_count:  cover property (count_wr_i ##6 inc);
    c_ext_edge:  cover property (css && !prescaler_assign && rise_q);
    c_sup_clear: cover property (prescaler_assign && supervision_clear_i);
    c_flag_clr:  cover property (flag_q && overflow_flag_clr_i);

endmodule

`default_nettype wire
